// [verif/mcs_host_model.sv]
// Host-side model: read-clear strobes and module reset pulses
`default_nettype none
module mcs_host_model
(
  input  wire logic        ref_clk,        // 200 MHz clock
  input  wire logic        rst_b,          // Async reset, active low
  input  wire logic        clr_req,        // Bench asks for one read-clear
  input  wire logic [7:0]  clr_bits,       // Flags covered by that read
  input  wire logic        rst_req,        // Bench asks for a reset pulse
  input  wire logic [15:0] rst_len,        // Pulse length in cycles
  output logic             flag_clear,     // Read-clear strobe, one cycle
  output logic [7:0]       flag_clear_sel, // Flags cleared by the strobe
  output logic             module_reset_n  // Reset pin, active low
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cnt_q;

  // ==========================================================
  // Strobe and pulse generation
  // Outside a strobe the select is inverted every cycle, so a design that
  // ignores the strobe clears at random and is caught
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      flag_clear     <= 1'b0;
      flag_clear_sel <= 8'hA5;
      module_reset_n <= 1'b1;
      cnt_q          <= 16'h0000;
    end
    else
    begin
      flag_clear     <= clr_req;
      flag_clear_sel <= clr_req ? clr_bits : ~flag_clear_sel;
      if (rst_req)
      begin
        module_reset_n <= 1'b0;
        cnt_q          <= rst_len;
      end
      else if (cnt_q > 16'h0001)
        cnt_q <= cnt_q - 16'h0001;
      else
        module_reset_n <= 1'b1;
    end
  end
endmodule // mcs_host_model
`default_nettype wire

// [verif/tb_mcs_ctl_status.sv]
// Self-checking bench for the control and status timing block
`include "mcs_map.svh"
`default_nettype none
module tb_mcs_ctl_status;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MGMT = 3000;
  logic        ref_clk, rst_b, low_power_select, laser_disable, pin_is_disable;
  logic        sw_laser_disable, fast_disable_cap, fibre_check_done, fibre_clean;
  logic        flag_clear, clr_req, rst_req, module_reset_n;
  logic        management_startup, mgmt_ready, interrupt_out_n, laser_drive_en, low_power_active;
  logic [7:0]  flag_cond, flag_clear_sel, flag_mask, flags, clr_bits, m, b;
  logic [7:0]  pwr_tmo, path_tmo, laser_tmo;
  logic [15:0] rst_len;
  logic [31:0] seed;
  int          mismatches, checked;

  // ==========================================================
  // Design, host model and clock
  mcs_ctl_status #(.MGMT_INIT_CYC(MGMT), .CHECK_CYC(200), .PWR_UP_ADV(8'h05),
                   .PATH_INIT_ADV(8'h06), .LASER_ON_ADV(8'h07)) u_dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .module_reset_n(module_reset_n),
    .low_power_select(low_power_select), .laser_disable(laser_disable),
    .pin_is_disable(pin_is_disable), .sw_laser_disable(sw_laser_disable),
    .fast_disable_cap(fast_disable_cap), .fibre_check_done(fibre_check_done),
    .fibre_clean(fibre_clean), .flag_cond(flag_cond), .flag_clear(flag_clear),
    .flag_clear_sel(flag_clear_sel), .flag_mask(flag_mask),
    .management_startup(management_startup), .mgmt_ready(mgmt_ready),
    .interrupt_out_n(interrupt_out_n), .flags(flags), .laser_drive_en(laser_drive_en),
    .low_power_active(low_power_active), .power_up_timeout(pwr_tmo),
    .path_init_timeout(path_tmo), .laser_on_timeout(laser_tmo));

  mcs_host_model u_host (
    .ref_clk(ref_clk), .rst_b(rst_b), .clr_req(clr_req), .clr_bits(clr_bits),
    .rst_req(rst_req), .rst_len(rst_len), .flag_clear(flag_clear),
    .flag_clear_sel(flag_clear_sel), .module_reset_n(module_reset_n));

  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // Interrupt is low while any unmasked flag stands
  function automatic logic exp_int(logic [7:0] f, logic [7:0] k);
    return ~|(f & ~k);
  endfunction

  function automatic logic pick(int w);
    case (w)
      0: return mgmt_ready;
      1: return interrupt_out_n;
      2: return laser_drive_en;
      3: return low_power_active;
      default: return management_startup;
    endcase
  endfunction

  task automatic cmp(logic [7:0] got, logic [7:0] exp, string what);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // Bounded wait for one output to reach a level, then compare
  task automatic wait_sig(int w, logic v, int n, string what);
    int k;
    k = 0;
    while (k < n && pick(w) !== v)
    begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    cmp({7'h00, pick(w)}, {7'h00, v}, what);
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic host_clear(logic [7:0] bits);
    @(posedge ref_clk);
    clr_bits <= bits;
    clr_req  <= 1'b1;
    @(posedge ref_clk);
    clr_req <= 1'b0;
    cyc(4);
  endtask

  task automatic host_reset(int len);
    @(posedge ref_clk);
    rst_len <= len[15:0];
    rst_req <= 1'b1;
    @(posedge ref_clk);
    rst_req <= 1'b0;
  endtask

  task automatic set_flag(logic [7:0] bits, logic [7:0] k);
    @(posedge ref_clk);
    flag_cond <= bits;
    flag_mask <= k;
    @(posedge ref_clk);
    flag_cond <= 8'h00;
    cyc(3);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ==========================================================
  // Watchdog sized well above the expected run of about 8500 cycles
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    mismatches++;
    $display("unexpected at %0t: watchdog expired", $time);
    end_of_test();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    {rst_b, low_power_select, laser_disable, pin_is_disable, sw_laser_disable} = 5'h00;
    {clr_req, rst_req, flag_cond, flag_mask, clr_bits, rst_len} = 34'h000000000;
    {fast_disable_cap, fibre_check_done, fibre_clean} = 3'h7;
    mismatches = 0;
    checked = 0;
    seed = 32'h00018236;
    cyc(19);
    cmp({mgmt_ready, interrupt_out_n, laser_drive_en}, 8'h02, "outputs in reset");
    @(posedge ref_clk);
    rst_b <= 1'b1;
    cyc(1);
    wait_sig(0, 1'b1, MGMT + 2, "ready after power-on");
    cmp(flags, 8'h00, "clean fibre check");
    cmp({pwr_tmo, path_tmo, laser_tmo} == 24'h050607, 8'h01, "advertised durations");
    wait_sig(2, 1'b1, 2, "laser on when ready");
    // Every flag bit with a random mask, then its mask bit flipped, then cleared
    for (int i = 0; i < 8; i++)
    begin
      seed = xs(seed);
      m = seed[7:0];
      b = 8'h01 << i;
      set_flag(b, m);
      cmp(flags, b, "flag set");
      cmp({7'h00, interrupt_out_n}, {7'h00, exp_int(b, m)}, "interrupt with mask");
      @(posedge ref_clk);
      flag_mask <= m ^ b;
      cyc(2);
      cmp({7'h00, interrupt_out_n}, {7'h00, exp_int(b, m ^ b)}, "mask flipped");
      host_clear(b);
      cmp({flags, 7'h00, interrupt_out_n}, 16'h0001, "read clears");
    end
    // Back to back flags: clearing one leaves the other holding the line low
    @(posedge ref_clk);
    flag_cond <= 8'h01;
    flag_mask <= 8'h00;
    set_flag(8'h02, 8'h00);
    host_clear(8'h01);
    cmp({flags, 7'h00, interrupt_out_n}, 16'h0200, "one of two cleared");
    host_clear(8'h02);
    wait_sig(1, 1'b1, 1, "both cleared");
    // Laser disable by bit, by pin and by the shared pin in its disable meaning; low_power_active checked in both meanings
    @(posedge ref_clk);
    sw_laser_disable <= 1'b1;
    wait_sig(2, 1'b0, 2, "bit disables laser");
    @(posedge ref_clk);
    sw_laser_disable <= 1'b0;
    wait_sig(2, 1'b1, 2, "bit clear restores laser");
    @(posedge ref_clk);
    laser_disable <= 1'b1;
    wait_sig(2, 1'b0, 4, "pin disables laser fast");
    @(posedge ref_clk);
    laser_disable <= 1'b0;
    low_power_select <= 1'b1;
    wait_sig(3, 1'b1, 4, "low-power meaning");
    @(posedge ref_clk);
    pin_is_disable <= 1'b1;
    wait_sig(3, 1'b0, 2, "disable meaning");
    cmp({7'h00, laser_drive_en}, 8'h00, "shared pin disables laser");
    @(posedge ref_clk);
    low_power_select <= 1'b0;
    wait_sig(2, 1'b1, 4, "laser back on");
    // Short reset pulse is ignored, long one restarts with a dirty fibre
    host_reset(1000);
    cyc(1100);
    cmp({7'h00, mgmt_ready}, 8'h01, "short reset ignored");
    @(posedge ref_clk);
    fibre_clean <= 1'b0;
    host_reset(`MCS_US_CYC(`MCS_T_RESET_MIN_US));
    wait_sig(4, 1'b1, 2010, "long reset starts");
    cmp({mgmt_ready, interrupt_out_n, laser_drive_en}, 8'h02, "outputs in module reset");
    wait_sig(0, 1'b1, MGMT + 60, "ready after reset pin");
    cmp(flags, 8'h04, "dirty fibre flagged");
    wait_sig(1, 1'b0, 2, "dirty fibre interrupt");
    host_clear(8'h04);
    cmp({flags, 7'h00, interrupt_out_n}, 16'h0001, "fibre flag cleared");
    // Fibre test that never reports: the check phase times out and flags it
    @(posedge ref_clk);
    fibre_check_done <= 1'b0;
    fibre_clean      <= 1'b1;
    host_reset(`MCS_US_CYC(`MCS_T_RESET_MIN_US));
    wait_sig(4, 1'b1, 2010, "reset before check timeout");
    wait_sig(0, 1'b1, MGMT + 60, "ready after check timeout");
    cmp(flags, 8'h04, "untested fibre flagged");
    host_clear(8'h04);
    cmp({flags, 7'h00, interrupt_out_n}, 16'h0001, "untested flag cleared");
    end_of_test();
  end
endmodule // tb_mcs_ctl_status
`default_nettype wire

// [verilog/mcs_ctl_status.sv]
// Soft control and status timing block of a pluggable laser module
// ==========================================================
`include "mcs_map.svh"
`default_nettype none
module mcs_ctl_status
  import mcs_pkg::*;
#(
  parameter int unsigned       MGMT_INIT_CYC = `MCS_MS_CYC(`MCS_T_MGMT_INIT_MS),
  parameter int unsigned       CHECK_CYC     = `MCS_MS_CYC(`MCS_T_CHECK_MS),
  parameter logic [7:0]        PWR_UP_ADV    = 8'h01,
  parameter logic [7:0]        PATH_INIT_ADV = 8'h01,
  parameter logic [7:0]        LASER_ON_ADV  = 8'h01
)
(
  input  wire logic               ref_clk,             // 200 MHz clock
  input  wire logic               rst_b,               // Power-on reset, active low
  input  wire logic               module_reset_n,      // Reset pin from host
  input  wire logic               low_power_select,    // Shared low-power / disable pin
  input  wire logic               laser_disable,       // Fast laser-disable pin
  input  wire logic               pin_is_disable,      // Shared pin acts as laser disable
  input  wire logic               sw_laser_disable,    // Laser-disable control bit
  input  wire logic               fast_disable_cap,    // Fast disable advertised
  input  wire logic               fibre_check_done,    // Fibre test finished
  input  wire logic               fibre_clean,         // Fibre test result
  input  wire logic [`MCS_NFLAG-1:0] flag_cond,        // Flag-raising conditions
  input  wire logic               flag_clear,          // Host read of flags, one cycle
  input  wire logic [`MCS_NFLAG-1:0] flag_clear_sel,   // Flags covered by that read
  input  wire logic [`MCS_NFLAG-1:0] flag_mask,        // Interrupt masks
  output logic                    management_startup,  // Start-up in progress
  output logic                    mgmt_ready,          // Bus transactions may be acked
  output logic                    interrupt_out_n,     // Interrupt, active low
  output logic [`MCS_NFLAG-1:0]   flags,               // Latched flags
  output logic                    laser_drive_en,      // Optical output enabled
  output logic                    low_power_active,    // Low-power mode in force
  output logic [7:0]              power_up_timeout,    // Advertised power-up time
  output logic [7:0]              path_init_timeout,   // Advertised path init time
  output logic [7:0]              laser_on_timeout     // Advertised laser on time
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [1:0]              lp_sync;
    logic [1:0]              ld_sync;
    mcs_state_e              st;
    logic                    busy;
    logic                    ready;
    logic                    laser_on;
    logic                    low_pwr;
    logic [`MCS_NFLAG-1:0]   flg;
    logic                    int_n;
    logic [7:0]              adv_pwr;
    logic [7:0]              adv_path;
    logic [7:0]              adv_laser;
  } mcs_top_s;

  mcs_top_s s_q;
  mcs_top_s s_d;

  mcs_tmr_if phase_tif ();
  mcs_tmr_if dead_tif ();

  logic                  rst_hold;
  logic                  dis_req;
  logic [`MCS_NFLAG-1:0] raise;

  // ==========================================================
  // Sub-blocks
  mcs_reset_filter u_rst_filter (
    .ref_clk        (ref_clk),
    .rst_b          (rst_b),
    .module_reset_n (module_reset_n),
    .reset_hold     (rst_hold)
  );

  // Timers clear only on power-on reset; every start reloads them, so a
  // module reset cannot leave a stale expiry behind for the next start-up
  mcs_timer u_phase_tmr (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .tif     (phase_tif)
  );

  mcs_timer u_dead_tmr (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .tif     (dead_tif)
  );

  // Interrupt reduction, shared by the next-state logic and the checks
  function automatic logic int_level(input logic [`MCS_NFLAG-1:0] f, input logic [`MCS_NFLAG-1:0] m);
    int_level = ~|(f & ~m);
  endfunction

  // ==========================================================
  // Next state
  always_comb
  begin
    s_d             = s_q;
    phase_tif.start = 1'b0;
    phase_tif.limit = mcs_cnt_t'(`MCS_HW_INIT_CYC);
    dead_tif.start  = 1'b0;
    dead_tif.limit  = mcs_cnt_t'(MGMT_INIT_CYC);

    // Pins cross into this clock through two stages
    s_d.lp_sync = {s_q.lp_sync[0], low_power_select};
    s_d.ld_sync = {s_q.ld_sync[0], laser_disable};

    // Shared pin meaning follows the select on the next edge
    s_d.low_pwr = s_q.lp_sync[1] && !pin_is_disable;

    // Fibre check result is a flag source, the rest come from outside
    raise = flag_cond;

    // Start-up sequence
    case (s_q.st)
      MCS_ST_RESET:
      begin
        if (!rst_hold)
        begin
          phase_tif.start = 1'b1;
          dead_tif.start  = 1'b1;
          s_d.st          = MCS_ST_INIT;
        end
      end
      MCS_ST_INIT:
      begin
        if (phase_tif.done)
        begin
          phase_tif.start = 1'b1;
          phase_tif.limit = mcs_cnt_t'(CHECK_CYC);
          s_d.st          = MCS_ST_CHECK;
        end
      end
      MCS_ST_CHECK:
      begin
        // A dirty or untested fibre is reported, it does not stall start-up
        if (fibre_check_done || phase_tif.done || dead_tif.done)
        begin
          raise[`MCS_FLG_FIBRE] = !(fibre_check_done && fibre_clean);
          s_d.st                = MCS_ST_READY;
          s_d.ready             = 1'b1;
          s_d.busy              = 1'b0;
        end
      end
      MCS_ST_READY:
      begin
        s_d.ready = 1'b1;
      end
      default:
      begin
        s_d.st = MCS_ST_RESET;
      end
    endcase

    // The fast-disable capability needs no path of its own: the pin already
    // acts within a few cycles, far inside the fast limit
    // Optical output: any disable source wins, the bit within one edge, the pins within three
    dis_req = sw_laser_disable
           || s_q.ld_sync[1]
           || (s_q.lp_sync[1] && pin_is_disable)
           || s_q.lp_sync[1];
    s_d.laser_on = (s_q.st == MCS_ST_READY) && !dis_req;

    // Flags: a new event wins over a clear in the same cycle
    if (flag_clear)
      s_d.flg = s_q.flg & ~flag_clear_sel;
    s_d.flg = s_d.flg | raise;
    s_d.int_n = int_level(s_q.flg, flag_mask);

    // Advertised maximum durations
    s_d.adv_pwr   = PWR_UP_ADV;
    s_d.adv_path  = PATH_INIT_ADV;
    s_d.adv_laser = LASER_ON_ADV;

    // Module reset overrides state, status, laser and flags, not the pin stages, low-power mode or advertised times
    if (rst_hold)
    begin
      s_d.st       = MCS_ST_RESET;
      s_d.busy     = 1'b1;
      s_d.ready    = 1'b0;
      s_d.laser_on = 1'b0;
      s_d.flg      = '0;
      s_d.int_n    = 1'b1;
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      s_q <= '{lp_sync: 2'h0, ld_sync: 2'h0, st: MCS_ST_RESET, busy: 1'b1, ready: 1'b0,
               laser_on: 1'b0, low_pwr: 1'b0, flg: '0, int_n: 1'b1,
               adv_pwr: `MCS_ADV_RST, adv_path: `MCS_ADV_RST, adv_laser: `MCS_ADV_RST};
    else
      s_q <= s_d;
  end

  // ==========================================================
  // Outputs, all straight from flip-flops
  assign management_startup = s_q.busy;
  assign mgmt_ready         = s_q.ready;
  assign interrupt_out_n    = s_q.int_n;
  assign flags              = s_q.flg;
  assign laser_drive_en     = s_q.laser_on;
  assign low_power_active   = s_q.low_pwr;
  assign power_up_timeout   = s_q.adv_pwr;
  assign path_init_timeout  = s_q.adv_path;
  assign laser_on_timeout   = s_q.adv_laser;

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  // Cycles spent since reset release without being ready
  mcs_cnt_t wait_cnt;
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      wait_cnt <= '0;
    else if (s_q.st == MCS_ST_RESET || s_q.ready)
      wait_cnt <= '0;
    else
      wait_cnt <= wait_cnt + mcs_cnt_t'(1);
  end

  a_startup_deadline : assert property (wait_cnt <= mcs_cnt_t'(MGMT_INIT_CYC) + mcs_cnt_t'(2))
    else $error("management not ready within start-up limit");

  a_ready_via_check : assert property ($rose(s_q.ready) |-> $past(s_q.st) == MCS_ST_CHECK)
    else $error("ready reached without output check");

  a_mode_change : assert property ($changed(pin_is_disable) && s_q.lp_sync[1] && !rst_hold
    |=> low_power_active == !$past(pin_is_disable))
    else $error("shared pin mode did not follow select");

  a_flag_set_int : assert property ((|(flag_cond & ~flag_mask)) && !rst_hold
    ##1 (!rst_hold && $stable(flag_mask)) |=> !interrupt_out_n)
    else $error("interrupt not asserted after condition");

  a_int_release : assert property (flag_clear && (flag_clear_sel == '1) && flag_cond == '0
    ##1 flag_cond == '0 |=> interrupt_out_n)
    else $error("interrupt not released after clear");

  a_sw_disable : assert property (sw_laser_disable |=> !laser_drive_en)
    else $error("laser not off after disable bit");

  a_pin_disable : assert property (laser_disable [*3] |=> !laser_drive_en)
    else $error("laser not off after disable pin");

  a_laser_restore : assert property (s_q.st == MCS_ST_READY && !dis_req && !rst_hold
    |=> laser_drive_en)
    else $error("laser not restored after disable cleared");

  a_fault_flag : assert property (flag_cond[`MCS_FLG_LASER_FAULT] && !rst_hold
    |=> flags[`MCS_FLG_LASER_FAULT])
    else $error("laser fault flag not set");

  a_flag_latch : assert property (flags != '0 && !flag_clear && !rst_hold
    |=> (flags & $past(flags)) == $past(flags))
    else $error("flag lost without clear");

  a_mask_gate : assert property (!rst_hold ##1 !rst_hold
    |-> interrupt_out_n == int_level($past(flags), $past(flag_mask)))
    else $error("interrupt does not match flags and masks");

  // Start-up result, module reset and shared pin side effects
  a_fibre_report : assert property ($rose(mgmt_ready) && !$past(fibre_check_done && fibre_clean)
    |-> flags[`MCS_FLG_FIBRE])
    else $error("unclean fibre check not flagged");

  a_reset_quiet : assert property (rst_hold
    |=> !mgmt_ready && !laser_drive_en && interrupt_out_n && flags == '0)
    else $error("outputs not quiet during module reset");

  a_low_power_dark : assert property (low_power_active |-> !laser_drive_en)
    else $error("laser on while low-power mode in force");

  c_ready      : cover property ($rose(mgmt_ready));
  c_int_cycle  : cover property ($fell(interrupt_out_n) ##[1:50] $rose(interrupt_out_n));
  c_dirty      : cover property ($rose(flags[`MCS_FLG_FIBRE]));
  c_pin_reset  : cover property (mgmt_ready ##1 rst_hold);
  // Fibre test never reports, the check phase runs out
  c_check_tmo  : cover property (s_q.st == MCS_ST_CHECK && !fibre_check_done && phase_tif.done);

endmodule // mcs_ctl_status
`default_nettype wire

// [verilog/mcs_map.svh]
// Constants for the module control and status timing block
`ifndef MCS_MAP_SVH
`define MCS_MAP_SVH

// ==========================================================
// Clock and time conversion
`define MCS_CLK_MHZ         200
`define MCS_US_CYC(t)       ((t) * `MCS_CLK_MHZ)
`define MCS_MS_CYC(t)       ((t) * 1000 * `MCS_CLK_MHZ)

// ==========================================================
// Times as printed
`define MCS_T_MGMT_INIT_MS  2000
`define MCS_T_RESET_MIN_US  10
`define MCS_T_CHECK_MS      50
`define MCS_HW_INIT_CYC     1000

// ==========================================================
// Flag vector layout
`define MCS_NFLAG           8
`define MCS_FLG_LASER_FAULT 0
`define MCS_FLG_RX_LOSS     1
`define MCS_FLG_FIBRE       2

// ==========================================================
// Widths and reset values
`define MCS_TMR_W           32
`define MCS_RST_CNT_W       12
`define MCS_ADV_RST         8'h00

`endif

// [verilog/mcs_pkg.sv]
// Types shared by the control and status timing block
`default_nettype none
package mcs_pkg;

  // ==========================================================
  // Start-up sequence states
  typedef enum logic [1:0] {
    MCS_ST_RESET,
    MCS_ST_INIT,
    MCS_ST_CHECK,
    MCS_ST_READY
  } mcs_state_e;

  // ==========================================================
  // Width of the shared timer count
  typedef logic [31:0] mcs_cnt_t;

endpackage
`default_nettype wire

// [verilog/mcs_reset_filter.sv]
// Synchroniser and minimum-width detector for the module reset pin
`include "mcs_map.svh"
`default_nettype none
module mcs_reset_filter
  import mcs_pkg::*;
(
  input  wire logic ref_clk,        // 200 MHz clock
  input  wire logic rst_b,          // Async reset, active low
  input  wire logic module_reset_n, // Reset pin from host
  output logic      reset_hold      // Valid reset pulse seen, pin still low
);

  localparam logic [`MCS_RST_CNT_W-1:0] MIN_CYC = `MCS_RST_CNT_W'(`MCS_US_CYC(`MCS_T_RESET_MIN_US));

  typedef struct packed {
    logic [1:0]                sync;
    logic [`MCS_RST_CNT_W-1:0] cnt;
    logic                      hold;
  } mcs_rf_s;

  mcs_rf_s s_q;
  mcs_rf_s s_d;

  // ==========================================================
  // Short glitches are ignored; only a full-width low pulse resets
  always_comb
  begin
    s_d      = s_q;
    s_d.sync = {s_q.sync[0], module_reset_n};
    if (s_q.sync[1])
    begin
      s_d.cnt  = '0;
      s_d.hold = 1'b0;
    end
    else
    begin
      // Hold rises on the edge that counts the last low sample, so a pulse of
      // exactly the minimum width is taken
      if (s_q.cnt != MIN_CYC)
        s_d.cnt = s_q.cnt + `MCS_RST_CNT_W'(1);
      s_d.hold = (s_d.cnt == MIN_CYC);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      s_q <= '{sync: 2'h3, cnt: '0, hold: 1'b0};
    else
      s_q <= s_d;
  end

  assign reset_hold = s_q.hold;

  // ==========================================================
  // Checks
  a_reset_min_width : assert property (@(posedge ref_clk) disable iff (!rst_b)
    $rose(s_q.hold) |-> s_q.cnt == MIN_CYC && !$past(s_q.sync[1]))
    else $error("reset taken before minimum low width");

endmodule // mcs_reset_filter
`default_nettype wire

// [verilog/mcs_timer.sv]
// One-shot cycle timer used for start-up phases and deadline
`include "mcs_map.svh"
`default_nettype none
module mcs_timer
  import mcs_pkg::*;
(
  input  wire logic ref_clk, // 200 MHz clock
  input  wire logic rst_b,   // Async reset, active low
  mcs_tmr_if.tmr    tif      // Start, limit and done
);

  typedef struct packed {
    mcs_cnt_t cnt;
    logic     run;
    logic     done;
  } mcs_tmr_s;

  mcs_tmr_s s_q;
  mcs_tmr_s s_d;

  // ==========================================================
  // Countdown; done stays up so a late reader cannot miss it
  always_comb
  begin
    s_d = s_q;
    if (tif.start)
    begin
      s_d.cnt  = tif.limit - mcs_cnt_t'(1);
      s_d.run  = 1'b1;
      s_d.done = 1'b0;
    end
    else if (s_q.run)
    begin
      if (s_q.cnt == '0)
      begin
        s_d.run  = 1'b0;
        s_d.done = 1'b1;
      end
      else
      begin
        s_d.cnt = s_q.cnt - mcs_cnt_t'(1);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign tif.done = s_q.done;

endmodule // mcs_timer
`default_nettype wire

// [verilog/mcs_tmr_if.sv]
// Carrier between the controller and its one-shot timers
`default_nettype none
interface mcs_tmr_if;
  import mcs_pkg::*;
  logic     start; // Load and run, one cycle
  mcs_cnt_t limit; // Cycles until done
  logic     done;  // Expired, holds until next start

  modport ctl (output start, output limit, input done);
  modport tmr (input start, input limit, output done);
endinterface
`default_nettype wire
